// *** hdl/ccdt_consts.svh ***
// Offsets, field positions, reset values and timing counts of the core.
// Assumes it is included by bare name wherever the values are needed.
`ifndef CCDT_CONSTS_SVH
`define CCDT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CCDT_OFS_COMMAND 8'h00
`define CCDT_OFS_ACC 8'h04
`define CCDT_OFS_AUX 8'h08
`define CCDT_OFS_OPERAND 8'h0c
`define CCDT_OFS_STATUS 8'h10
`define CCDT_OFS_PC 8'h14
`define CCDT_OFS_STACK 8'h18
`define CCDT_OFS_BITBYTE 8'h1c
`define CCDT_OFS_PSW 8'hd0

// ----------------------------------------------------------------------
// Status word bit positions and reset values
// ----------------------------------------------------------------------
`define CCDT_PSW_CY 7
`define CCDT_PSW_AC 6
`define CCDT_PSW_F0 5
`define CCDT_PSW_RS1 4
`define CCDT_PSW_RS0 3
`define CCDT_PSW_OV 2
`define CCDT_PSW_F1 1
`define CCDT_PSW_P 0
`define CCDT_PSW_RESET 8'h00
`define CCDT_SP_RESET 8'h07
`define CCDT_PC_RESET 16'h0000

// ----------------------------------------------------------------------
// Machine cycle timing, one index per oscillator period (S1P1 = 0)
// ----------------------------------------------------------------------
`define CCDT_PERIODS_PER_CYCLE 4'hc
`define CCDT_PH_S1P2 4'h1
`define CCDT_PH_S2P1 4'h2
`define CCDT_PH_S4P2 4'h7
`define CCDT_PH_S5P1 4'h8
`define CCDT_PH_S6P1 4'ha
`define CCDT_PH_S6P2 4'hb
`define CCDT_CYCLES_LONG 2'h3
`define CCDT_CYCLES_TWO 2'h1
`define CCDT_CYCLES_ONE 2'h0

`endif

// *** hdl/ccdt_pkg.sv ***
// Types shared by the core datapath and its environment.
// Assumes nothing beyond a SystemVerilog compiler.
package ccdt_pkg;

  // --------------------------------------------------------------------
  // Operations
  // --------------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_MUL, OP_DIV, OP_INC, OP_DEC, OP_DA,
    OP_CMP, OP_AND, OP_OR, OP_XOR, OP_CPL, OP_RL, OP_RR, OP_SWAP,
    OP_SETB, OP_CLRB, OP_CPLB, OP_JNB, OP_JBC, OP_MOVCB, OP_MOVBC,
    OP_ANLC, OP_ANLCN, OP_ORLC, OP_ORLCN, OP_PUSH, OP_POP, OP_CALL,
    OP_RET, OP_XMOVE
  } ccdt_op_type;

  // Command register layout, least significant field last.
  typedef struct packed {
    logic [16:0] unused;
    logic [2:0] bit_num;
    logic [2:0] reg_num;
    logic src_reg;
    logic use_carry;
    logic two_byte;
    ccdt_op_type op;
  } ccdt_cmd_type;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_PENDING, SEQ_RUN} ccdt_seq_type;

  // Values held between the phase 1 computation and phase 2 transfer.
  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] aux;
    logic cy;
    logic ac;
    logic ov;
  } ccdt_alu_type;

endpackage

// *** hdl/ccdt_core.sv ***
// Datapath and machine-cycle sequencer of an 8-bit controller core.
// Assumes an APB master on pclk and program and external data memories
// that answer synchronously to pclk, one pclk per oscillator period.
`timescale 1ns/100ps
`include "ccdt_consts.svh"

module ccdt_core
  import ccdt_pkg::*;
#(
  parameter int DMEM_WORDS = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory
  output logic [15:0] code_addr,
  output logic code_fetch,
  output logic addr_latch_strobe,
  input wire logic [7:0] code_byte,
  // External data memory
  output logic [15:0] xdata_addr,
  output logic xdata_strobe,
  // Sequencer state
  output logic busy
);

  localparam int AW = $clog2(DMEM_WORDS);

  // Refuse memory sizes that bank and stack indexing cannot serve.
  if (DMEM_WORDS < 32 || DMEM_WORDS > 256 ||
      (DMEM_WORDS & (DMEM_WORDS - 1)) != 0) begin
    $error("DMEM_WORDS must be a power of two from 32 to 256");
  end

  typedef struct packed {
    logic [DMEM_WORDS-1:0][7:0] dmem;
    ccdt_seq_type seq;
    ccdt_cmd_type cmd;
    ccdt_alu_type hold;
    logic [3:0] ph;
    logic [1:0] cyc_left;
    logic first_cyc;
    logic skip_cyc;
    logic [7:0] acc;
    logic [7:0] aux;
    logic [7:0] operand;
    logic [7:0] bit_byte;
    logic [7:0] ir;
    logic [6:0] psw_hi;
    logic [7:0] sp;
    logic [15:0] pc;
    logic [31:0] rdata;
    logic slverr;
    logic ale;
    logic fetch;
    logic xstrobe;
  } ccdt_state_type;

  ccdt_state_type st;
  ccdt_state_type next_st;

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  function automatic logic [1:0] extra_cycles(input ccdt_op_type op);
    case (op)
      OP_MUL, OP_DIV: extra_cycles = `CCDT_CYCLES_LONG;
      OP_XMOVE, OP_PUSH, OP_POP, OP_CALL, OP_RET:
        extra_cycles = `CCDT_CYCLES_TWO;
      default: extra_cycles = `CCDT_CYCLES_ONE;
    endcase
  endfunction

  function automatic logic strobe_phase(input logic [3:0] ph);
    strobe_phase = ph == `CCDT_PH_S1P2 || ph == `CCDT_PH_S2P1 ||
                   ph == `CCDT_PH_S4P2 || ph == `CCDT_PH_S5P1;
  endfunction

  function automatic logic [7:0] psw_of(input logic [6:0] hi,
                                        input logic [7:0] acc);
    psw_of = {hi, ^acc};
  endfunction

  // --------------------------------------------------------------------
  // Combinational datapath
  // --------------------------------------------------------------------
  logic [AW-1:0] bank_base;
  logic [7:0] opnd;
  logic cy;
  logic sel_bit;
  ccdt_alu_type alu;
  logic [8:0] wide;
  logic [4:0] nib;
  logic [15:0] prod;
  logic [7:0] program_status_word;
  logic [15:0] rel_target;

  always_comb begin
    bank_base = AW'({st.psw_hi[`CCDT_PSW_RS1 - 1],
                     st.psw_hi[`CCDT_PSW_RS0 - 1], 3'h0});
    opnd = st.cmd.src_reg ? st.dmem[bank_base + AW'(st.cmd.reg_num)]
                          : st.operand;
    cy = st.psw_hi[`CCDT_PSW_CY - 1];
    sel_bit = st.bit_byte[st.cmd.bit_num];
    program_status_word = psw_of(st.psw_hi, st.acc);
    rel_target = st.pc + {{8{st.operand[7]}}, st.operand};
    alu.acc = st.acc;
    alu.aux = st.aux;
    alu.cy = cy;
    alu.ac = st.psw_hi[`CCDT_PSW_AC - 1];
    alu.ov = st.psw_hi[`CCDT_PSW_OV - 1];
    wide = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    case (st.cmd.op)
      OP_ADD: begin
        wide = {1'b0, st.acc} + {1'b0, opnd} +
               {8'h00, st.cmd.use_carry & cy};
        nib = {1'b0, st.acc[3:0]} + {1'b0, opnd[3:0]} +
              {4'h0, st.cmd.use_carry & cy};
        alu.acc = wide[7:0];
        alu.cy = wide[8];
        alu.ac = nib[4];
        alu.ov = (st.acc[7] == opnd[7]) && (wide[7] != st.acc[7]);
      end
      OP_SUB: begin
        wide = {1'b0, st.acc} - {1'b0, opnd} -
               {8'h00, st.cmd.use_carry & cy};
        nib = {1'b0, st.acc[3:0]} - {1'b0, opnd[3:0]} -
              {4'h0, st.cmd.use_carry & cy};
        alu.acc = wide[7:0];
        alu.cy = wide[8];
        alu.ac = nib[4];
        alu.ov = (st.acc[7] != opnd[7]) && (wide[7] != st.acc[7]);
      end
      OP_MUL: begin
        prod = st.acc * st.aux;
        alu.acc = prod[7:0];
        alu.aux = prod[15:8];
        alu.cy = 1'b0;
        alu.ov = prod[15:8] != 8'h00;
      end
      OP_DIV: begin
        alu.cy = 1'b0;
        alu.ov = st.aux == 8'h00;
        if (st.aux != 8'h00) begin
          alu.acc = st.acc / st.aux;
          alu.aux = st.acc % st.aux;
        end
      end
      OP_INC: alu.acc = st.acc + 8'h01;
      OP_DEC: alu.acc = st.acc - 8'h01;
      OP_DA: begin
        wide = {1'b0, st.acc};
        if (wide[3:0] > 4'h9 || st.psw_hi[`CCDT_PSW_AC - 1]) begin
          wide = wide + 9'h006;
        end
        if (wide[7:4] > 4'h9 || wide[8] || cy) begin
          wide = wide + 9'h060;
          alu.cy = 1'b1;
        end
        alu.acc = wide[7:0];
      end
      OP_CMP: alu.cy = st.acc < opnd;
      OP_AND: alu.acc = st.acc & opnd;
      OP_OR: alu.acc = st.acc | opnd;
      OP_XOR: alu.acc = st.acc ^ opnd;
      OP_CPL: alu.acc = ~st.acc;
      OP_RL: alu.acc = {st.acc[6:0], st.acc[7]};
      OP_RR: alu.acc = {st.acc[0], st.acc[7:1]};
      OP_SWAP: alu.acc = {st.acc[3:0], st.acc[7:4]};
      OP_MOVCB: alu.cy = sel_bit;
      OP_ANLC: alu.cy = cy & sel_bit;
      OP_ANLCN: alu.cy = cy & ~sel_bit;
      OP_ORLC: alu.cy = cy | sel_bit;
      OP_ORLCN: alu.cy = cy | ~sel_bit;
      default: alu.acc = st.acc;
    endcase
  end

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  logic setup;
  logic access;
  logic last_cyc;
  logic [AW-1:0] sp_up1;
  logic [AW-1:0] sp_up2;
  logic [AW-1:0] sp_at;
  logic [AW-1:0] sp_dn1;

  always_comb begin
    next_st = st;
    setup = psel && !penable;
    access = psel && penable;
    last_cyc = st.seq == SEQ_RUN && st.cyc_left == 2'h0;
    sp_up1 = AW'(st.sp + 8'h01);
    sp_up2 = AW'(st.sp + 8'h02);
    sp_at = AW'(st.sp);
    sp_dn1 = AW'(st.sp - 8'h01);

    // Machine cycle phase counter runs free from reset.
    next_st.ph = (st.ph == `CCDT_PH_S6P2) ? 4'h0 : st.ph + 4'h1;

    // Instruction start on a machine cycle boundary.
    if (st.seq == SEQ_PENDING && st.ph == `CCDT_PH_S6P2) begin
      next_st.seq = SEQ_RUN;
      next_st.first_cyc = 1'b1;
      next_st.skip_cyc = 1'b0;
      next_st.cyc_left = extra_cycles(st.cmd.op);
    end

    if (st.seq == SEQ_RUN) begin
      if (st.ph == `CCDT_PH_S1P2 && st.first_cyc) begin
        next_st.ir = code_byte;
        next_st.pc = st.pc + 16'h0001;
      end
      if (st.ph == `CCDT_PH_S4P2 && st.first_cyc &&
          st.cmd.two_byte) begin
        next_st.operand = code_byte;
        next_st.pc = st.pc + 16'h0001;
      end
      if (st.ph == `CCDT_PH_S6P1) begin
        next_st.hold = alu;
      end
      if (st.ph == `CCDT_PH_S6P2) begin
        next_st.first_cyc = 1'b0;
        next_st.cyc_left = st.cyc_left - 2'h1;
        next_st.skip_cyc = st.cmd.op == OP_XMOVE && st.first_cyc;
      end
      if (st.ph == `CCDT_PH_S6P2 && last_cyc) begin
        next_st.seq = SEQ_IDLE;
        next_st.acc = st.hold.acc;
        next_st.aux = st.hold.aux;
        next_st.psw_hi[`CCDT_PSW_CY - 1] = st.hold.cy;
        next_st.psw_hi[`CCDT_PSW_AC - 1] = st.hold.ac;
        next_st.psw_hi[`CCDT_PSW_OV - 1] = st.hold.ov;
        case (st.cmd.op)
          OP_SETB: next_st.bit_byte[st.cmd.bit_num] = 1'b1;
          OP_CLRB: next_st.bit_byte[st.cmd.bit_num] = 1'b0;
          OP_CPLB: next_st.bit_byte[st.cmd.bit_num] = ~sel_bit;
          OP_MOVBC: next_st.bit_byte[st.cmd.bit_num] = cy;
          OP_JNB: begin
            if (!sel_bit) begin
              next_st.pc = rel_target;
            end
          end
          OP_JBC: begin
            if (sel_bit) begin
              next_st.pc = rel_target;
              next_st.bit_byte[st.cmd.bit_num] = 1'b0;
            end
          end
          OP_CMP: begin
            if (st.acc != opnd) begin
              next_st.pc = rel_target;
            end
          end
          OP_PUSH: begin
            next_st.sp = st.sp + 8'h01;
            next_st.dmem[sp_up1] = st.acc;
          end
          OP_POP: begin
            next_st.acc = st.dmem[sp_at];
            next_st.sp = st.sp - 8'h01;
          end
          OP_CALL: begin
            next_st.sp = st.sp + 8'h02;
            next_st.dmem[sp_up1] = st.pc[7:0];
            next_st.dmem[sp_up2] = st.pc[15:8];
            next_st.pc = rel_target;
          end
          OP_RET: begin
            next_st.pc = {st.dmem[sp_at], st.dmem[sp_dn1]};
            next_st.sp = st.sp - 8'h02;
          end
          default: next_st.pc = next_st.pc;
        endcase
      end
    end

    // APB read data and error are prepared in the setup cycle.
    if (setup) begin
      next_st.slverr = 1'b0;
      case (paddr)
        `CCDT_OFS_COMMAND: next_st.rdata = st.cmd;
        `CCDT_OFS_ACC: next_st.rdata = {24'h000000, st.acc};
        `CCDT_OFS_AUX: next_st.rdata = {24'h000000, st.aux};
        `CCDT_OFS_OPERAND: next_st.rdata = {24'h000000, st.operand};
        `CCDT_OFS_STATUS: next_st.rdata = {8'h00, st.ir, 3'h0,
          5'(bank_base), st.ph, 2'h0, st.seq};
        `CCDT_OFS_PC: next_st.rdata = {16'h0000, st.pc};
        `CCDT_OFS_STACK: next_st.rdata = {24'h000000, st.sp};
        `CCDT_OFS_BITBYTE: next_st.rdata = {24'h000000, st.bit_byte};
        `CCDT_OFS_PSW: next_st.rdata = {24'h000000, program_status_word};
        default: begin
          next_st.rdata = 32'h00000000;
          next_st.slverr = 1'b1;
        end
      endcase
      // Writes are refused while an instruction is queued or running.
      if (pwrite && (st.seq != SEQ_IDLE || paddr == `CCDT_OFS_STATUS)) begin
        next_st.slverr = 1'b1;
      end
    end

    if (access && pwrite && !st.slverr) begin
      case (paddr)
        `CCDT_OFS_COMMAND: begin
          next_st.cmd = pwdata;
          next_st.seq = SEQ_PENDING;
        end
        `CCDT_OFS_ACC: next_st.acc = pwdata[7:0];
        `CCDT_OFS_AUX: next_st.aux = pwdata[7:0];
        `CCDT_OFS_OPERAND: next_st.operand = pwdata[7:0];
        `CCDT_OFS_PC: next_st.pc = pwdata[15:0];
        `CCDT_OFS_STACK: next_st.sp = pwdata[7:0];
        `CCDT_OFS_BITBYTE: next_st.bit_byte = pwdata[7:0];
        `CCDT_OFS_PSW: next_st.psw_hi = pwdata[7:1];
        default: next_st.slverr = st.slverr;
      endcase
    end

    // Strobes follow the next phase so the registered pins line up.
    next_st.ale = strobe_phase(next_st.ph) &&
                  !(next_st.seq == SEQ_RUN && next_st.skip_cyc);
    next_st.fetch = next_st.seq == SEQ_RUN && !next_st.skip_cyc &&
                    (next_st.ph == `CCDT_PH_S1P2 ||
                     next_st.ph == `CCDT_PH_S4P2);
    next_st.xstrobe = next_st.seq == SEQ_RUN && next_st.skip_cyc &&
                      next_st.ph >= `CCDT_PH_S2P1 &&
                      next_st.ph <= `CCDT_PH_S5P1;
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.seq <= SEQ_IDLE;
      st.cmd <= '0;
      st.psw_hi <= 7'(`CCDT_PSW_RESET >> 1);
      st.sp <= `CCDT_SP_RESET;
      st.pc <= `CCDT_PC_RESET;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign prdata = st.rdata;
  assign pready = 1'b1;
  assign pslverr = st.slverr && psel && penable;
  assign code_addr = st.pc;
  assign code_fetch = st.fetch;
  assign addr_latch_strobe = st.ale;
  assign xdata_addr = {8'h00, st.operand};
  assign xdata_strobe = st.xstrobe;
  assign busy = st.seq != SEQ_IDLE;

endmodule

// *** dv/ccdt_core_monitor.sv ***
// Concurrent checks on the core's strobe, fetch and busy timing.
// Assumes it is bound to the core, one pclk per oscillator period.
`timescale 1ns/100ps
module ccdt_core_monitor
  import ccdt_pkg::*;
#(
  parameter int DMEM_WORDS = 32
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Memories and sequencer
  input wire logic [15:0] code_addr,
  input wire logic code_fetch,
  input wire logic addr_latch_strobe,
  input wire logic [7:0] code_byte,
  input wire logic [15:0] xdata_addr,
  input wire logic xdata_strobe,
  input wire logic busy
);
  // ------------------------------------------------------------------
  // Timing properties
  // ------------------------------------------------------------------
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_ale_width;
    $rose(addr_latch_strobe) |=> addr_latch_strobe ##1 !addr_latch_strobe;
  endproperty
  a_ale_width: assert property (p_ale_width) else $error("ale width");
  property p_ale_gap;
    $rose(addr_latch_strobe) |=> (!$rose(addr_latch_strobe))[*5];
  endproperty
  a_ale_gap: assert property (p_ale_gap) else $error("ale gap");
  property p_ale_period;
    $rose(addr_latch_strobe) && !busy |-> ##6 $rose(addr_latch_strobe);
  endproperty
  a_ale_period: assert property (p_ale_period) else $error("ale period");
  property p_fetch_ale;
    code_fetch |-> $rose(addr_latch_strobe);
  endproperty
  a_fetch_ale: assert property (p_fetch_ale) else $error("fetch slot");
  property p_fetch_pulse;
    code_fetch |=> !code_fetch;
  endproperty
  a_fetch_pulse: assert property (p_fetch_pulse) else $error("fetch len");
  property p_fetch_busy;
    code_fetch |-> busy;
  endproperty
  a_fetch_busy: assert property (p_fetch_busy) else $error("idle fetch");
  property p_xs_width;
    $rose(xdata_strobe) |-> xdata_strobe[*7] ##1 !xdata_strobe;
  endproperty
  a_xs_width: assert property (p_xs_width) else $error("xdata width");
  property p_xs_quiet;
    xdata_strobe |-> !code_fetch && !addr_latch_strobe;
  endproperty
  a_xs_quiet: assert property (p_xs_quiet) else $error("xdata fetch");
  property p_busy_bound;
    $rose(busy) |-> ##[1:64] !busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("busy long");
  c_xmove: cover property ($rose(xdata_strobe));
  c_done: cover property ($fell(busy));
  c_err: cover property (pslverr);
endmodule

bind ccdt_core ccdt_core_monitor #(.DMEM_WORDS(DMEM_WORDS)) u_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .code_addr(code_addr),
  .code_fetch(code_fetch), .addr_latch_strobe(addr_latch_strobe),
  .code_byte(code_byte), .xdata_addr(xdata_addr),
  .xdata_strobe(xdata_strobe), .busy(busy)
);

// *** dv/ccdt_code_mem.sv ***
// Program memory model that answers the core's code fetches.
// Assumes the core samples the byte at the edge ending its fetch strobe.
`timescale 1ns/100ps
module ccdt_code_mem (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Fetch side
  input wire logic [15:0] code_addr,
  input wire logic code_fetch,
  output logic [7:0] code_byte
);
  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  logic [7:0] last_byte;

  // Outside a fetch the bus shows the inverse of what it last carried.
  assign code_byte = code_fetch ? (code_addr[7:0] ^ 8'h5a) : ~last_byte;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_byte <= 8'h00;
    end else begin
      last_byte <= code_byte;
    end
  end
endmodule

// *** dv/ccdt_core_tb.sv ***
// Self-checking bench: APB register tasks and instruction runs.
// Assumes the core, its package, the code memory model and the checker.
`timescale 1ns/100ps
`include "ccdt_consts.svh"
module ccdt_core_tb
  import ccdt_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, code_fetch, addr_latch_strobe, xdata_strobe, busy;
  logic [15:0] code_addr, xdata_addr;
  logic [7:0] code_byte;
  int miscompares = 0;
  int num_checks = 0;
  int cycles = 0;
  ccdt_op_type sop[4] = '{OP_PUSH, OP_POP, OP_CALL, OP_RET};
  logic [7:0] ssp[4] = '{8'h08, 8'h07, 8'h09, 8'h07};

  ccdt_core uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .code_addr(code_addr),
    .code_fetch(code_fetch), .addr_latch_strobe(addr_latch_strobe),
    .code_byte(code_byte), .xdata_addr(xdata_addr),
    .xdata_strobe(xdata_strobe), .busy(busy)
  );
  ccdt_code_mem mem (
    .pclk(pclk), .presetn(presetn), .code_addr(code_addr),
    .code_fetch(code_fetch), .code_byte(code_byte)
  );

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    num_checks++;
    if (got !== ex) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic ee);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Loads operands, runs one command, then checks results and timing.
  task automatic run(input logic [31:0] cmd, input logic [39:0] ins,
                     input logic [31:0] outs, input int n,
                     input logic [15:0] dp);
    int fc;
    int k;
    fc = 0;
    k = 0;
    apb(1'b1, `CCDT_OFS_PSW, {24'h0, ins[39:32]}, 1'b0);
    apb(1'b1, `CCDT_OFS_ACC, {24'h0, ins[31:24]}, 1'b0);
    apb(1'b1, `CCDT_OFS_AUX, {24'h0, ins[23:16]}, 1'b0);
    apb(1'b1, `CCDT_OFS_OPERAND, {24'h0, ins[15:8]}, 1'b0);
    apb(1'b1, `CCDT_OFS_BITBYTE, {24'h0, ins[7:0]}, 1'b0);
    apb(1'b1, `CCDT_OFS_PC, 32'h40, 1'b0);
    apb(1'b1, `CCDT_OFS_COMMAND, cmd, 1'b0);
    do begin
      @(posedge pclk);
      k++;
      fc += code_fetch;
      if (xdata_strobe === 1'b1) begin
        chk("xaddr", {24'h0, ins[15:8]}, {16'h0, xdata_addr});
      end
    end while (busy === 1'b1 && k < 100);
    chk("cycles", 32'h1, {31'h0, k >= 12 * n && k <= 12 * n + 13});
    chk("fetches", (cmd[5:0] == OP_XMOVE) ? 2 : 2 * n, fc);
    apb(1'b0, `CCDT_OFS_ACC, 32'h0, 1'b0);
    chk("acc", {24'h0, outs[31:24]}, rd);
    apb(1'b0, `CCDT_OFS_AUX, 32'h0, 1'b0);
    chk("aux", {24'h0, outs[23:16]}, rd);
    apb(1'b0, `CCDT_OFS_PSW, 32'h0, 1'b0);
    chk("psw", {24'h0, outs[15:8]}, rd);
    apb(1'b0, `CCDT_OFS_BITBYTE, 32'h0, 1'b0);
    chk("bitbyte", {24'h0, outs[7:0]}, rd);
    apb(1'b0, `CCDT_OFS_PC, 32'h0, 1'b0);
    if (dp !== 16'hffff) chk("pc", {16'h0, 16'h40 + dp}, rd);
    if (dp !== 16'hffff) begin
      chk("code_addr", {16'h0, 16'h40 + dp}, {16'h0, code_addr});
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    forever #4 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 12000) begin
      miscompares++;
      complete_run();
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CCDT_OFS_PSW, 32'h0, 1'b0);
    chk("psw", 32'h00, rd);
    apb(1'b0, `CCDT_OFS_STACK, 32'h0, 1'b0);
    chk("sp", 32'h07, rd);
    apb(1'b1, `CCDT_OFS_STACK, 32'h2a, 1'b0);
    apb(1'b0, `CCDT_OFS_STACK, 32'h0, 1'b0);
    chk("sp", 32'h2a, rd);
    apb(1'b1, `CCDT_OFS_STACK, 32'h07, 1'b0);
    apb(1'b0, 8'h20, 32'h0, 1'b1);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, `CCDT_OFS_STATUS, 32'h0, 1'b1);
    apb(1'b1, `CCDT_OFS_ACC, 32'h03, 1'b0);
    apb(1'b1, `CCDT_OFS_PSW, 32'hff, 1'b0);
    apb(1'b0, `CCDT_OFS_PSW, 32'h0, 1'b0);
    chk("psw", 32'hfe, rd);
    apb(1'b1, `CCDT_OFS_ACC, 32'h07, 1'b0);
    apb(1'b0, `CCDT_OFS_PSW, 32'h0, 1'b0);
    chk("psw", 32'hff, rd);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `CCDT_OFS_PSW, 32'(i * 8), 1'b0);
      apb(1'b0, `CCDT_OFS_STATUS, 32'h0, 1'b0);
      chk("bank", 32'(i * 8), {27'h0, rd[12:8]});
    end
    run(OP_ADD, 40'h00_3c_00_d5_00, 32'h11_00_c0_00, 1, 16'h1);
    run(OP_SUB, 40'h00_10_00_01_00, 32'h0f_00_40_00, 1, 16'h1);
    run(OP_MUL, 40'h00_50_a0_00_00, 32'h00_32_04_00, 4, 16'h1);
    run(OP_DIV, 40'h00_fb_12_00_00, 32'h0d_11_01_00, 4, 16'h1);
    run(OP_INC, 40'h00_ff_00_00_00, 32'h00_00_00_00, 1, 16'h1);
    run(OP_DEC, 40'h00_00_00_00_00, 32'hff_00_00_00, 1, 16'h1);
    run(OP_DA, 40'h00_9a_00_00_00, 32'h00_00_80_00, 1, 16'h1);
    run(OP_CMP, 40'h00_10_00_20_00, 32'h10_00_81_00, 1, 16'h21);
    run(OP_AND, 40'h00_f0_00_3c_00, 32'h30_00_00_00, 1, 16'h1);
    run(OP_OR, 40'h00_f0_00_0c_00, 32'hfc_00_00_00, 1, 16'h1);
    run(OP_XOR, 40'h00_5a_00_ff_00, 32'ha5_00_00_00, 1, 16'h1);
    run(OP_CPL, 40'h00_0f_00_00_00, 32'hf0_00_00_00, 1, 16'h1);
    run(OP_RL, 40'h00_81_00_00_00, 32'h03_00_00_00, 1, 16'h1);
    run(OP_RR, 40'h00_01_00_00_00, 32'h80_00_01_00, 1, 16'h1);
    run(OP_SWAP, 40'h00_5a_00_00_00, 32'ha5_00_00_00, 1, 16'h1);
    run(OP_SETB | 32'h3000, 40'h0, 32'h08, 1, 16'h1);
    run(OP_CLRB | 32'h3000, 40'hff, 32'hf7, 1, 16'h1);
    run(OP_JNB | 32'h3000, 40'h08, 32'h08, 1, 16'h1);
    run(OP_JBC | 32'h3000, 40'h10_08, 32'h00, 1, 16'h11);
    run(OP_ANLCN | 32'h3000, 40'h80_00_00_00_08, 32'h08, 1, 16'h1);
    run(OP_ORLC | 32'h3000, 40'h08, 32'h80_08, 1, 16'h1);
    run(OP_ADD | 32'h80, 40'h80_01_00_01_00, 32'h03_00_00_00, 1, 16'h1);
    run(OP_MOVCB | 32'h3000, 40'h08, 32'h80_08, 1, 16'h1);
    run(OP_CPLB | 32'h3000, 40'h08, 32'h00, 1, 16'h1);
    run(OP_MOVBC | 32'h3000, 40'h80_00_00_00_00, 32'h80_08, 1, 16'h1);
    run(OP_JNB | 32'h3000, 40'h10_00, 32'h00, 1, 16'h11);
    run(OP_ANLC | 32'h3000, 40'h80_00_00_00_00, 32'h00, 1, 16'h1);
    run(OP_ORLCN | 32'h3000, 40'h0, 32'h80_00, 1, 16'h1);
    run(OP_XMOVE, 40'h33_00, 32'h0, 2, 16'h1);
    run(OP_XOR | 32'h40, 40'h0, 32'h1b_00_00_00, 1, 16'h2);
    foreach (sop[i]) begin
      run(sop[i], 40'h0, 32'h0, 2, 16'h1);
      apb(1'b0, `CCDT_OFS_STACK, 32'h0, 1'b0);
      chk("sp", {24'h0, ssp[i]}, rd);
    end
    run(OP_ADD | 32'h100, {8'h08, 32'h0}, 32'h41_00_08_00, 1, 16'h1);
    apb(1'b1, `CCDT_OFS_COMMAND, OP_MUL, 1'b0);
    apb(1'b1, `CCDT_OFS_COMMAND, OP_NOP, 1'b1);
    for (int i = 0; i < 80 && busy === 1'b1; i++) @(posedge pclk);
    complete_run();
  end
endmodule
